// >>> shared/shift_store_regs.svh
`ifndef SHIFT_STORE_REGS_SVH
`define SHIFT_STORE_REGS_SVH
// ----------------------------------------
// Constants
// ----------------------------------------
`define STAGE_COUNT    8
`define STAGE_RESET    8'h00
`define FIFO_DEPTH     8
`define FIFO_WIDTH     8
`endif

// >>> shared/shift_store_pkg.sv
`include "shift_store_regs.svh"
package shift_store_pkg;
   typedef logic [`STAGE_COUNT-1:0] stage_vec_t;
   typedef enum logic [1:0] {clk_low, clk_high} clk_state_t;
endpackage

// >>> design/word_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;
   logic             next_out_valid;
   logic [WIDTH-1:0] next_out_data;

   // Handshake terms; head word and its valid leave from flops
   assign push        = in_valid_i && (count != (AW+1)'(DEPTH));
   assign pop         = out_valid_o && out_ready_i;
   assign in_ready_o  = (count != (AW+1)'(DEPTH));

   // Pointer next values
   always_comb begin
      next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
      next_out_valid = (next_count != '0);
      // Word written into an emptied buffer becomes the head at once
      next_out_data  = (push && (wr_ptr == next_rd_ptr)) ? in_data_i : mem[next_rd_ptr];
   end

   // Pointer registers
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
         out_valid_o <= next_out_valid;
         out_data_o  <= next_out_data;
      end
   end

   // Storage, one flop row per entry
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_mem
         always_ff @(posedge clk_sys_i) begin
            if (push && wr_ptr == AW'(gi)) begin
               mem[gi] <= in_data_i;
            end
         end
      end
   endgenerate
endmodule // word_fifo
`default_nettype wire

// >>> design/serial_shift_store_register.sv
`timescale 1ns/10ps
`default_nettype none
`include "shift_store_regs.svh"
// Contract
// - Eight stages, eight-bit latch, tri-state outputs
// - Rising shift clock loads input, stages advance
// - Latch follows stages while transfer high
// - Parallel outputs float unless drive high
// - Rise output shows seventh stage on rise
// - Fall output copies last stage on fall
module serial_shift_store_register (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   input  wire logic       shift_clock_i,
   input  wire logic       serial_in_i,
   input  wire logic       latch_transfer_i,
   input  wire logic       output_drive_i,
   output logic      [7:0] parallel_out_o,
   output logic      [7:0] parallel_out_oe_n_o,
   output logic            rise_serial_out_o,
   output logic            fall_serial_out_o,
   output logic            capture_valid_o,
   input  wire logic       capture_ready_i,
   output logic      [7:0] capture_data_o
);
   // ----------------------------------------
   // Edge detection of the shift clock
   // ----------------------------------------
   logic                       clk_prev;
   logic                       rise;
   logic                       fall;
   shift_store_pkg::stage_vec_t stages;
   shift_store_pkg::stage_vec_t next_stages;
   shift_store_pkg::stage_vec_t latch;
   shift_store_pkg::stage_vec_t next_latch;
   logic                       next_rise_out;
   logic                       next_fall_out;
   logic                       next_clk_prev;
   logic      [7:0]            next_par;
   logic      [7:0]            next_oe_n;
   logic                       fifo_in_ready;
   logic                       fifo_push;
   logic                       strobe_prev;
   logic                       next_strobe_prev;

   assign rise = shift_clock_i && !clk_prev;
   assign fall = !shift_clock_i && clk_prev;

   // ----------------------------------------
   // Shift stages, latch and serial outputs
   // ----------------------------------------
   // Next-state computation
   always_comb begin
      next_clk_prev    = shift_clock_i;
      next_stages      = stages;
      next_latch       = latch;
      next_rise_out    = rise_serial_out_o;
      next_fall_out    = fall_serial_out_o;
      next_strobe_prev = latch_transfer_i;
      if (rise) begin
         next_stages   = {stages[6:0], serial_in_i};
         next_rise_out = stages[6];
      end
      if (fall) begin
         next_fall_out = stages[7];
      end
      if (latch_transfer_i) begin
         next_latch = next_stages;
      end
      next_par  = next_latch;
      next_oe_n = {8{!output_drive_i}};
   end

   // Registers
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         clk_prev            <= 1'b0;
         stages              <= `STAGE_RESET;
         latch               <= `STAGE_RESET;
         rise_serial_out_o   <= 1'b0;
         fall_serial_out_o   <= 1'b0;
         parallel_out_o      <= 8'h00;
         parallel_out_oe_n_o <= 8'hFF;
         strobe_prev         <= 1'b0;
      end else begin
         clk_prev            <= next_clk_prev;
         stages              <= next_stages;
         latch               <= next_latch;
         rise_serial_out_o   <= next_rise_out;
         fall_serial_out_o   <= next_fall_out;
         parallel_out_o      <= next_par;
         parallel_out_oe_n_o <= next_oe_n;
         strobe_prev         <= next_strobe_prev;
      end
   end

   // ----------------------------------------
   // Capture FIFO: latch word on strobe fall
   // ----------------------------------------
   assign fifo_push = strobe_prev && !latch_transfer_i;

   word_fifo #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .in_data_i   (latch),
      .in_valid_i  (fifo_push),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (capture_data_o),
      .out_valid_o (capture_valid_o),
      .out_ready_i (capture_ready_i)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Shift clock seen rising
   sequence s_rise;
      !$past(shift_clock_i) && shift_clock_i;
   endsequence

   // Shift clock seen falling
   sequence s_fall;
      $past(shift_clock_i) && !shift_clock_i;
   endsequence

   // Latched word accepted by the capture buffer
   sequence s_word_stored;
      fifo_push && fifo_in_ready;
   endsequence

   a_shift_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_rise |=> stages == {$past(stages[6:0]), $past(serial_in_i)})
      else $error("Shift stages did not advance on rise");

   a_stage_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !(shift_clock_i && !$past(shift_clock_i)) |=> stages == $past(stages))
      else $error("Shift stages changed without rise");

   a_rise_out: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_rise |=> rise_serial_out_o == $past(stages[6]))
      else $error("Rise output wrong");

   a_rise_stable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_fall |=> $stable(rise_serial_out_o))
      else $error("Rise output moved on fall");

   a_fall_out: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_fall |=> fall_serial_out_o == $past(stages[7]))
      else $error("Fall output wrong");

   a_latch_follow: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      latch_transfer_i |=> (latch == stages) && (parallel_out_o == stages))
      else $error("Latch not following stages");

   a_latch_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !latch_transfer_i |=> $stable(latch))
      else $error("Latch changed while transfer low");

   a_drive_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      1'b1 |=> parallel_out_oe_n_o == {8{!$past(output_drive_i)}})
      else $error("Output enable mismatch");

   a_par_value: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      1'b1 |=> parallel_out_o == latch)
      else $error("Parallel outputs differ from latch");

   // Parallel outputs frozen while transfer low
   a_par_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !latch_transfer_i |=> $stable(parallel_out_o))
      else $error("Parallel outputs moved while transfer low");

   // Fall output untouched by a rising edge
   a_fall_stable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_rise |=> $stable(fall_serial_out_o))
      else $error("Fall output moved on rise");

   // Rise serial output keeps running while outputs float
   a_serial_free: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_rise ##0 !output_drive_i |=> rise_serial_out_o == $past(stages[6]))
      else $error("Rise output stalled while floated");

   // Pins released one cycle after drive drops
   a_oe_float: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !output_drive_i |=> parallel_out_oe_n_o == 8'hFF)
      else $error("Parallel pins driven while drive low");

   // ----------------------------------------
   // Capture buffer checks
   // ----------------------------------------
   // Accepted word makes the buffer non-empty
   a_push_accept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_word_stored |=> capture_valid_o)
      else $error("Accepted word not visible");

   // Word into an empty buffer shows at the head
   a_capture_word: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_word_stored ##0 !capture_valid_o |=> capture_data_o == $past(latch))
      else $error("Head word differs from latched word");

   // Stalled head stays put
   a_stall_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      capture_valid_o && !capture_ready_i |=> capture_valid_o && $stable(capture_data_o))
      else $error("Head word lost while stalled");

   // ----------------------------------------
   // Reset checks
   // ----------------------------------------
   // Pins floated and cleared the cycle after reset is sampled low
   a_reset_float: assert property (@(posedge clk_sys_i)
      !rst_n_i |=> (parallel_out_oe_n_o == 8'hFF) && (parallel_out_o == 8'h00))
      else $error("Outputs not floated and cleared by reset");

   // Stages, latch, serial outputs and buffer cleared
   a_reset_clear: assert property (@(posedge clk_sys_i)
      !rst_n_i |=> (stages == `STAGE_RESET) && (latch == `STAGE_RESET)
         && !rise_serial_out_o && !fall_serial_out_o && !capture_valid_o)
      else $error("State not cleared by reset");
endmodule // serial_shift_store_register
`default_nettype wire

// >>> test/shift_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
// Controller driving data, shift clock, strobe and drive
module shift_ctl_model (
   input  wire logic clk_sys_i,
   input  wire logic cascade_i,
   output logic      shift_clock_o,
   output logic      serial_o,
   output logic      strobe_o,
   output logic      drive_o
);
   // First stages of the next device in the chain
   logic [7:0] chain_stages;
   // Outputs stay floated until a word is latched
   initial begin
      shift_clock_o = 1'b0;
      serial_o      = 1'b0;
      strobe_o      = 1'b0;
      drive_o       = 1'b0;
      chain_stages  = 8'h00;
   end
   // Waits n edges, then settles past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   // Shifts a byte, first bit lands in the last stage
   task automatic shift_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         serial_o      = b[i];
         chain_stages  = {chain_stages[6:0], cascade_i};
         shift_clock_o = 1'b1;
         tick(2);
         shift_clock_o = 1'b0;
         serial_o      = ~b[i]; // Data no longer held
         tick(2);
      end
   endtask
   task automatic set_strobe(input logic s);
      strobe_o = s;
      tick(2);
   endtask
   task automatic set_drive(input logic d);
      drive_o = d;
      tick(2);
   endtask
endmodule // shift_ctl_model
`default_nettype wire

// >>> test/serial_shift_store_register_tb.sv
`timescale 1ns/10ps
`default_nettype none
module serial_shift_store_register_tb;
   logic       clk_sys_i, rst_n_i, capture_ready_i;
   logic       shift_clock, serial_in, latch_transfer, output_drive;
   logic [7:0] parallel_out, oe_n, capture_data;
   logic       rise_out, fall_out, capture_valid;
   int         fails = 0;
   int         compares = 0;
   // Clock
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   shift_ctl_model ctl (
      .clk_sys_i     (clk_sys_i),
      .cascade_i     (rise_out),
      .shift_clock_o (shift_clock),
      .serial_o      (serial_in),
      .strobe_o      (latch_transfer),
      .drive_o       (output_drive)
   );
   serial_shift_store_register dut (
      .clk_sys_i           (clk_sys_i),
      .rst_n_i             (rst_n_i),
      .shift_clock_i       (shift_clock),
      .serial_in_i         (serial_in),
      .latch_transfer_i    (latch_transfer),
      .output_drive_i      (output_drive),
      .parallel_out_o      (parallel_out),
      .parallel_out_oe_n_o (oe_n),
      .rise_serial_out_o   (rise_out),
      .fall_serial_out_o   (fall_out),
      .capture_valid_o     (capture_valid),
      .capture_ready_i     (capture_ready_i),
      .capture_data_o      (capture_data)
   );
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Word shifted with strobe low, then latched and driven
   task automatic load_then_show();
      ctl.shift_byte(8'hA5);
      check("held", 8'h00, parallel_out);
      ctl.set_strobe(1'b1);
      ctl.set_strobe(1'b0);
      check("latched", 8'hA5, parallel_out);
      check("rise", 8'h01, {7'h00, rise_out});
      check("fall", 8'h01, {7'h00, fall_out});
      check("floated", 8'hFF, oe_n);
      ctl.set_drive(1'b1);
      check("driven", 8'h00, oe_n);
      check("shown", 8'hA5, parallel_out);
   endtask
   // Latch follows while strobe high, serial outs run while floated
   task automatic follow_while_floated();
      ctl.set_drive(1'b0);
      ctl.set_strobe(1'b1);
      ctl.shift_byte(8'h3C);
      ctl.set_strobe(1'b0);
      check("follow", 8'h3C, parallel_out);
      check("float", 8'hFF, oe_n);
      check("rise_hiz", 8'h00, {7'h00, rise_out});
      check("fall_hiz", 8'h00, {7'h00, fall_out});
   endtask
   // Nine latched words into a stalled buffer of eight
   task automatic fill_and_drain();
      int n;
      capture_ready_i = 1'b0;
      for (int i = 0; i < 9; i++) begin
         ctl.shift_byte(8'h10 + 8'(i));
         ctl.set_strobe(1'b1);
         ctl.set_strobe(1'b0);
      end
      capture_ready_i = 1'b1;
      for (int i = 0; i < 8; i++) begin
         n = 0;
         while (capture_valid !== 1'b1 && n < 20) begin
            ctl.tick(1);
            n++;
         end
         if (capture_valid !== 1'b1) begin
            fails++;
            $display("MISMATCH capture_valid expected 1 seen %b", capture_valid);
            return;
         end
         check("word", 8'h10 + 8'(i), capture_data);
         ctl.tick(1);
      end
      ctl.tick(3);
      check("empty", 8'h00, {7'h00, capture_valid});
   endtask
   // Reset in mid-run clears a driven, latched word
   task automatic reset_midrun();
      rst_n_i = 1'b0;
      ctl.tick(2);
      check("rst_par", 8'h00, parallel_out);
      check("rst_oe", 8'hFF, oe_n);
      check("rst_ser", 8'h00, {6'h00, rise_out, fall_out});
      check("rst_cap", 8'h00, {7'h00, capture_valid});
      rst_n_i = 1'b1;
      ctl.tick(2);
      check("rel_oe", 8'h00, oe_n);
      check("rel_par", 8'h00, parallel_out);
   endtask
   // First byte passes through into the modelled next device, second stays in own stages
   task automatic cascade_chain();
      ctl.shift_byte(8'h5A);
      ctl.shift_byte(8'hC3);
      check("chain_next", 8'h5A, ctl.chain_stages);
      check("chain_ser", 8'h03, {6'h00, rise_out, fall_out});
      ctl.set_strobe(1'b1);
      ctl.set_strobe(1'b0);
      check("chain_own", 8'hC3, parallel_out);
   endtask
   // Main sequence
   initial begin
      rst_n_i         = 1'b0;
      capture_ready_i = 1'b1;
      repeat (10) @(posedge clk_sys_i);
      #1;
      rst_n_i = 1'b1;
      ctl.tick(1);
      check("reset_out", 8'h00, parallel_out);
      check("reset_oe", 8'hFF, oe_n);
      load_then_show();
      reset_midrun();
      follow_while_floated();
      cascade_chain();
      fill_and_drain();
      give_verdict();
   end
endmodule // serial_shift_store_register_tb
`default_nettype wire
